// ===== rtl/cpw_pkg.sv
/*
 * Constants for the single-output pulse-width modulator block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes a register port with 4-bit byte addresses and 8-bit data.
 */
package cpw_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_TB_COUNT = 4'h0;
    localparam logic [3:0] OFS_PERIOD = 4'h1;
    localparam logic [3:0] OFS_TB_CTRL = 4'h2;
    localparam logic [3:0] OFS_U1_DUTY_WR = 4'h3;
    localparam logic [3:0] OFS_U1_DUTY_ACT = 4'h4;
    localparam logic [3:0] OFS_U1_MODE = 4'h5;
    localparam logic [3:0] OFS_U2_DUTY_WR = 4'h6;
    localparam logic [3:0] OFS_U2_DUTY_ACT = 4'h7;
    localparam logic [3:0] OFS_U2_MODE = 4'h8;
    localparam logic [3:0] OFS_SHUTDOWN = 4'h9;
    localparam logic [3:0] OFS_DEADBAND = 4'hA;

    // Timebase control fields.
    localparam int TB_PRESCALE_LSB = 0;
    localparam int TB_ON_BIT = 2;
    localparam int TB_POSTSCALE_LSB = 3;
    localparam logic [7:0] TB_CTRL_MASK = 8'h7F;

    // Mode control fields.
    localparam int MODE_DUTY_LOW_LSB = 4;
    localparam logic [1:0] MODE_PWM_UPPER = 2'h3;
    localparam logic [7:0] U1_MODE_MASK = 8'hFF;
    localparam logic [7:0] U2_MODE_MASK = 8'h3F;

    // Shutdown control fields.
    localparam int SD_ACTIVE_BIT = 7;
    localparam int SD_SOURCE_LSB = 4;

    // Prescale selection codes.
    localparam logic [1:0] PSC_DIV1 = 2'h0;
    localparam logic [1:0] PSC_DIV4 = 2'h1;

    // Reset values.
    localparam logic [7:0] RST_TB_COUNT = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_TB_CTRL = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN = 8'h00;
    localparam logic [7:0] RST_DEADBAND = 8'h00;

    // One instruction cycle lasts four oscillator periods.
    localparam int OSC_PER_INSTR = 4;
    localparam logic [1:0] Q_LAST = 2'(OSC_PER_INSTR - 1);

    localparam int NUM_UNITS = 2;

endpackage

// ===== rtl/cpw_duty_unit.sv
/*
 * One output unit: double-buffered 10-bit duty, duty comparison and the
 * output latch.
 * Assumes restart_i is a one-cycle pulse at each period restart and that
 * ext_cnt_i advances one step per oscillator period times the prescale.
 */
`timescale 1ns/1ps

module cpw_duty_unit (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic restart_i,
    input wire logic [9:0] ext_cnt_i,
    input wire logic pwm_on_i,
    input wire logic force_low_i,
    input wire logic [7:0] duty_msb_i,
    input wire logic [1:0] duty_lsb_i,
    input wire logic act_wr_i,
    input wire logic [7:0] act_wdata_i,
    output logic [7:0] act_byte_o,
    output logic pin_o
);

    logic [7:0] act_reg;
    logic [1:0] lat_reg;
    logic pin_reg;
    logic restart_d_reg;
    wire [9:0] duty_act = {act_reg, lat_reg};
    wire duty_zero = (duty_act == 10'h000);
    // A duty beyond the period never meets the count, so the pin stays high.
    wire duty_match = (duty_act == ext_cnt_i); // R7 R11
    wire load_duty = restart_i && pwm_on_i;
    wire cpu_load = act_wr_i && !pwm_on_i;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act_reg <= cpw_pkg::RST_DUTY;
            lat_reg <= 2'h0;
        end else if (load_duty) begin
            act_reg <= duty_msb_i; // R4
            lat_reg <= duty_lsb_i; // R9
        end else if (cpu_load) begin
            act_reg <= act_wdata_i; // R8
        end
    end

    // The pin rises one clock after the restart, when the fresh duty is
    // already active; rising on the restart edge itself would stretch every
    // high time by one clock.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            restart_d_reg <= 1'b0;
        end else begin
            restart_d_reg <= load_duty;
        end
    end

    // A restart takes priority over a match in the same cycle, so a new
    // period always begins from a known level.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_reg <= 1'b0;
        end else if (!pwm_on_i || force_low_i) begin
            pin_reg <= 1'b0; // R16
        end else if (restart_d_reg) begin
            pin_reg <= !duty_zero; // R3
        end else if (duty_match) begin
            pin_reg <= 1'b0; // R10
        end
    end

    assign act_byte_o = act_reg;
    assign pin_o = pin_reg;

endmodule // cpw_duty_unit

// ===== rtl/cpw_pwm_top.sv
/*
 * Top of the single-output pulse-width modulator: register port, timebase
 * with prescaler and postscaler, shutdown control and two output units.
 * Assumes a register master that holds strobes for one cycle, never both
 * at once, and reads data in the cycle after a read strobe.
 */
// The placing of the registers and the address-and-strobe port were left to the implementer.
// Functional notes
// R1 - Period is (limit+1) x 4 x prescale oscillator periods.
// R2 - Count equal to limit clears on next increment.
// R3 - Restart sets pin, unless duty is zero.
// R4 - Restart copies buffered duty into active duty.
// R5 - Postscaler only paces timer events, not period.
// R6 - Duty is byte plus mode bits 5:4.
// R7 - High time is duty x oscillator x prescale.
// R8 - Active duty byte read-only during PWM.
// R9 - Active byte plus hidden 2-bit latch.
// R10 - Clear pin when duty equals extended count.
// R11 - Duty beyond period keeps pin high.
// R12 - Prescale factors 1, 4, 16 by 2-bit field.
// R13 - Shutdown exists on first unit only.
// R14 - Software sets period, duty, direction, timer, mode.
// R15 - Mode upper bits both one select PWM.
// R16 - Zero mode control forces output latch low.
// R17 - Timebase counts only while enabled.
`timescale 1ns/1ps

module cpw_pwm_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic shutdown_req_i,
    output logic [7:0] rd_data_o,
    output logic pwm_pin1_o,
    output logic pwm_pin2_o,
    output logic tb_event_o
);

    // Register state.
    logic [7:0] tb_count_reg;
    logic [7:0] tb_count_next;
    logic [7:0] period_reg;
    logic [7:0] tb_ctrl_reg;
    logic [7:0] shutdown_reg;
    logic [7:0] shutdown_next;
    logic [7:0] deadband_reg;
    logic [7:0] duty_wr_reg [cpw_pkg::NUM_UNITS];
    logic [7:0] mode_reg [cpw_pkg::NUM_UNITS];
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;

    // Timebase state.
    logic [1:0] q_reg;
    logic [3:0] psc_reg;
    logic [3:0] psc_next;
    logic [3:0] post_reg;
    logic [3:0] post_next;
    logic tb_event_reg;

    // Per-unit results.
    logic [7:0] act_byte [cpw_pkg::NUM_UNITS];
    logic pin_out [cpw_pkg::NUM_UNITS];
    logic pwm_on [cpw_pkg::NUM_UNITS];
    logic act_wr [cpw_pkg::NUM_UNITS];
    logic duty_wr_hit [cpw_pkg::NUM_UNITS];
    logic mode_wr_hit [cpw_pkg::NUM_UNITS];

    // Address decode.
    wire wr_tb_count = wr_en_i && (addr_i == cpw_pkg::OFS_TB_COUNT);
    wire wr_period = wr_en_i && (addr_i == cpw_pkg::OFS_PERIOD);
    wire wr_tb_ctrl = wr_en_i && (addr_i == cpw_pkg::OFS_TB_CTRL);
    wire wr_shutdown = wr_en_i && (addr_i == cpw_pkg::OFS_SHUTDOWN);
    wire wr_deadband = wr_en_i && (addr_i == cpw_pkg::OFS_DEADBAND);

    assign duty_wr_hit[0] = wr_en_i && (addr_i == cpw_pkg::OFS_U1_DUTY_WR);
    assign duty_wr_hit[1] = wr_en_i && (addr_i == cpw_pkg::OFS_U2_DUTY_WR);
    assign mode_wr_hit[0] = wr_en_i && (addr_i == cpw_pkg::OFS_U1_MODE);
    assign mode_wr_hit[1] = wr_en_i && (addr_i == cpw_pkg::OFS_U2_MODE);
    assign act_wr[0] = wr_en_i && (addr_i == cpw_pkg::OFS_U1_DUTY_ACT);
    assign act_wr[1] = wr_en_i && (addr_i == cpw_pkg::OFS_U2_DUTY_ACT);

    // Timebase control fields.
    wire [1:0] psc_sel = tb_ctrl_reg[cpw_pkg::TB_PRESCALE_LSB +: 2];
    wire tb_on = tb_ctrl_reg[cpw_pkg::TB_ON_BIT];
    wire [3:0] post_sel = tb_ctrl_reg[cpw_pkg::TB_POSTSCALE_LSB +: 4];

    // One instruction cycle ends every fourth oscillator period.
    wire instr_end = (q_reg == cpw_pkg::Q_LAST);

    // Prescaler outputs a tick once per 1, 4 or 16 instruction cycles.
    wire psc_full4 = (psc_reg[1:0] == 2'h3);
    wire psc_full16 = (psc_reg == 4'hF);
    wire psc_done = (psc_sel == cpw_pkg::PSC_DIV1) ? 1'b1 :
                    (psc_sel == cpw_pkg::PSC_DIV4) ? psc_full4 : psc_full16; // R12
    wire tb_tick = tb_on && instr_end && psc_done; // R17

    // Period restart when the count has reached the limit at a tick.
    wire at_limit = (tb_count_reg == period_reg);
    wire restart = tb_tick && at_limit; // R2

    // Two low count bits below the 8-bit count give a resolution of one oscillator period times the prescale.
    wire [1:0] ext_low = (psc_sel == cpw_pkg::PSC_DIV1) ? q_reg :
                         (psc_sel == cpw_pkg::PSC_DIV4) ? psc_reg[1:0] :
                         psc_reg[3:2];
    wire [9:0] ext_cnt = {tb_count_reg, ext_low}; // R10 R1

    // Shutdown is armed when any source bit is set.
    wire sd_armed = (shutdown_reg[cpw_pkg::SD_SOURCE_LSB +: 3] != 3'h0);
    wire sd_event = sd_armed && shutdown_req_i;
    wire sd_active = shutdown_reg[cpw_pkg::SD_ACTIVE_BIT];

    // The postscaler divides the period events only.
    wire post_wrap = (post_reg == post_sel);

    // Oscillator phase within an instruction cycle always runs.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_reg <= 2'h0;
        end else begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // Prescaler and count restart on a count write so a new value starts
    // a whole tick.
    always_comb begin
        psc_next = psc_reg;
        if (wr_tb_count) begin
            psc_next = 4'h0;
        end else if (tb_on && instr_end) begin
            psc_next = tb_tick ? 4'h0 : psc_reg + 4'h1; // R12
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            psc_reg <= 4'h0;
        end else begin
            psc_reg <= psc_next;
        end
    end

    // A software write to the count overrides the increment.
    always_comb begin
        tb_count_next = tb_count_reg;
        if (wr_tb_count) begin
            tb_count_next = wr_data_i;
        end else if (restart) begin
            tb_count_next = 8'h00; // R2
        end else if (tb_tick) begin
            tb_count_next = tb_count_reg + 8'h01; // R17
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tb_count_reg <= cpw_pkg::RST_TB_COUNT;
        end else begin
            tb_count_reg <= tb_count_next;
        end
    end

    // Postscaler counts period restarts and emits the timer event.
    always_comb begin
        post_next = post_reg;
        if (restart) begin
            post_next = post_wrap ? 4'h0 : post_reg + 4'h1; // R5
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            post_reg <= 4'h0;
            tb_event_reg <= 1'b0;
        end else begin
            post_reg <= post_next;
            tb_event_reg <= restart && post_wrap; // R5
        end
    end

    // Plain configuration registers.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            period_reg <= cpw_pkg::RST_PERIOD;
            tb_ctrl_reg <= cpw_pkg::RST_TB_CTRL;
            deadband_reg <= cpw_pkg::RST_DEADBAND;
        end else begin
            if (wr_period) begin
                period_reg <= wr_data_i;
            end
            if (wr_tb_ctrl) begin
                tb_ctrl_reg <= wr_data_i & cpw_pkg::TB_CTRL_MASK;
            end
            if (wr_deadband) begin
                deadband_reg <= wr_data_i;
            end
        end
    end

    // The hardware event sets the active bit and wins over a clearing write.
    always_comb begin
        shutdown_next = shutdown_reg;
        if (wr_shutdown) begin
            shutdown_next = wr_data_i;
        end
        if (sd_event) begin
            shutdown_next[cpw_pkg::SD_ACTIVE_BIT] = 1'b1; // R13
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shutdown_reg <= cpw_pkg::RST_SHUTDOWN;
        end else begin
            shutdown_reg <= shutdown_next;
        end
    end

    // Duty write bytes and mode controls for both units; the second unit
    // has no steering bits, which read as zero.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int u = 0; u < cpw_pkg::NUM_UNITS; u++) begin
                duty_wr_reg[u] <= cpw_pkg::RST_DUTY;
                mode_reg[u] <= cpw_pkg::RST_MODE;
            end
        end else begin
            for (int u = 0; u < cpw_pkg::NUM_UNITS; u++) begin
                if (duty_wr_hit[u]) begin
                    duty_wr_reg[u] <= wr_data_i; // R4
                end
                if (mode_wr_hit[u]) begin
                    mode_reg[u] <= wr_data_i &
                        ((u == 0) ? cpw_pkg::U1_MODE_MASK : cpw_pkg::U2_MODE_MASK);
                end
            end
        end
    end

    // One output unit per channel; only the first honours shutdown.
    for (genvar g = 0; g < cpw_pkg::NUM_UNITS; g++) begin : gen_unit
        wire [1:0] mode_upper = mode_reg[g][3:2];
        wire [1:0] duty_low = mode_reg[g][cpw_pkg::MODE_DUTY_LOW_LSB +: 2]; // R6
        wire force_low = (g == 0) ? sd_active : 1'b0; // R13

        assign pwm_on[g] = (mode_upper == cpw_pkg::MODE_PWM_UPPER); // R15

        cpw_duty_unit u_duty (
            .ref_clk_i(ref_clk_i),
            .rst_b_i(rst_b_i),
            .restart_i(restart),
            .ext_cnt_i(ext_cnt),
            .pwm_on_i(pwm_on[g]),
            .force_low_i(force_low),
            .duty_msb_i(duty_wr_reg[g]),
            .duty_lsb_i(duty_low),
            .act_wr_i(act_wr[g]),
            .act_wdata_i(wr_data_i),
            .act_byte_o(act_byte[g]),
            .pin_o(pin_out[g])
        );
    end

    // Read data selection; unmapped offsets read as zero.
    always_comb begin
        rd_data_next = 8'h00;
        case (addr_i)
            cpw_pkg::OFS_TB_COUNT: begin
                rd_data_next = tb_count_reg;
            end
            cpw_pkg::OFS_PERIOD: begin
                rd_data_next = period_reg;
            end
            cpw_pkg::OFS_TB_CTRL: begin
                rd_data_next = tb_ctrl_reg;
            end
            cpw_pkg::OFS_U1_DUTY_WR: begin
                rd_data_next = duty_wr_reg[0];
            end
            cpw_pkg::OFS_U1_DUTY_ACT: begin
                rd_data_next = act_byte[0];
            end
            cpw_pkg::OFS_U1_MODE: begin
                rd_data_next = mode_reg[0];
            end
            cpw_pkg::OFS_U2_DUTY_WR: begin
                rd_data_next = duty_wr_reg[1];
            end
            cpw_pkg::OFS_U2_DUTY_ACT: begin
                rd_data_next = act_byte[1];
            end
            cpw_pkg::OFS_U2_MODE: begin
                rd_data_next = mode_reg[1];
            end
            cpw_pkg::OFS_SHUTDOWN: begin
                rd_data_next = shutdown_reg;
            end
            cpw_pkg::OFS_DEADBAND: begin
                rd_data_next = deadband_reg;
            end
            default: begin
                rd_data_next = 8'h00;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_en_i ? rd_data_next : 8'h00;
        end
    end

    assign rd_data_o = rd_data_reg;
    assign pwm_pin1_o = pin_out[0];
    assign pwm_pin2_o = pin_out[1];
    assign tb_event_o = tb_event_reg;

endmodule // cpw_pwm_top

// ===== bench/cpw_load_model.sv
/*
 * Passive load on one modulator pin: reports the last high time and the last
 * period, both in clock cycles.
 * Assumes the pin is a registered level in the same clock domain.
 */
`timescale 1ns/1ps

module cpw_load_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    output int high_o,
    output int period_o
);
    int cnt;
    logic last;

    // Figures are only meaningful once a whole period has been seen.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 0;
            last <= 1'b0;
            high_o <= 0;
            period_o <= 0;
        end else begin
            last <= pin_i;
            cnt <= (pin_i && !last) ? 1 : cnt + 1;
            if (pin_i && !last) begin
                period_o <= cnt;
            end
            if (!pin_i && last) begin
                high_o <= cnt;
            end
        end
    end
endmodule // cpw_load_model

// ===== bench/cpw_pwm_top_chk.sv
/*
 * Checker for the modulator top: register port timing and pin behaviour.
 * Assumes it is bound to cpw_pwm_top and sees only its ports.
 */
`timescale 1ns/1ps

module cpw_pwm_top_chk (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic shutdown_req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic pwm_pin1_o,
    input wire logic pwm_pin2_o,
    input wire logic tb_event_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    property wr_rd(a);
        wr_en_i && addr_i == a ##1 rd_en_i && addr_i == a |=> rd_data_o == $past(wr_data_i, 2);
    endproperty

    sequence rd_at(a);
        rd_en_i && addr_i == a && !wr_en_i;
    endsequence

    chk_period_readback: assert property (wr_rd(cpw_pkg::OFS_PERIOD))
        else $error("period readback wrong");
    chk_duty_readback: assert property (wr_rd(cpw_pkg::OFS_U1_DUTY_WR))
        else $error("duty byte readback wrong");
    chk_read_idle_zero: assert property (!rd_en_i |=> rd_data_o == 8'h00)
        else $error("read data outside read slot");
    chk_tbctl_top_zero: assert property (rd_at(cpw_pkg::OFS_TB_CTRL) |=> !rd_data_o[7])
        else $error("timebase control bit 7 not zero");
    chk_u2_mode_top: assert property (rd_at(cpw_pkg::OFS_U2_MODE) |=> rd_data_o[7:6] == 2'h0)
        else $error("unit 2 mode top bits not zero");
    chk_mode_off_low: assert property (rd_at(cpw_pkg::OFS_U1_MODE) ##1 rd_data_o[3:2] != 2'h3 && !wr_en_i
        |=> !pwm_pin1_o)
        else $error("pin 1 high outside modulation mode");
    chk_shutdown_low: assert property (rd_at(cpw_pkg::OFS_SHUTDOWN) ##1 rd_data_o[7] && !wr_en_i
        |=> !pwm_pin1_o)
        else $error("pin 1 high during shutdown");
    chk_zero_mode_low: assert property (wr_en_i && addr_i == cpw_pkg::OFS_U2_MODE && wr_data_i == 8'h00
        ##1 !wr_en_i |=> !pwm_pin2_o)
        else $error("pin 2 high after mode cleared");
    chk_event_single: assert property (tb_event_o |=> !tb_event_o)
        else $error("timer event longer than one cycle");

    cover property ($rose(pwm_pin1_o));
    cover property ($fell(pwm_pin2_o));
    cover property (tb_event_o);
endmodule // cpw_pwm_top_chk

bind cpw_pwm_top cpw_pwm_top_chk i_cpw_pwm_top_chk (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i),
    .shutdown_req_i(shutdown_req_i),
    .rd_data_o(rd_data_o),
    .pwm_pin1_o(pwm_pin1_o),
    .pwm_pin2_o(pwm_pin2_o),
    .tb_event_o(tb_event_o)
);

// ===== bench/test_cpw_pwm_top.sv
/*
 * Self-checking bench for the modulator top: registers, period and high time
 * at every prescale, duty buffering, shutdown, mode clear and timer events.
 * Assumes a 100 MHz clock and the register port described in the package.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s expected %0d seen %0d", n, e, g); end end

module test_cpw_pwm_top;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic shutdown_req_i = 1'b0;
    logic [7:0] rd_data_o;
    logic pwm_pin1_o;
    logic pwm_pin2_o;
    logic tb_event_o;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    int hi1, per1, hi2, per2, g, ps;

    cpw_pwm_top i_cpw_pwm_top (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .shutdown_req_i(shutdown_req_i),
        .rd_data_o(rd_data_o), .pwm_pin1_o(pwm_pin1_o), .pwm_pin2_o(pwm_pin2_o), .tb_event_o(tb_event_o));
    cpw_load_model i_cpw_load_model_1 (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pin_i(pwm_pin1_o),
        .high_o(hi1), .period_o(per1));
    cpw_load_model i_cpw_load_model_2 (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pin_i(pwm_pin2_o),
        .high_o(hi2), .period_o(per2));

    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task stop_test;
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // The whole run needs well under 5000 cycles; a hang is cut off here.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            stop_test();
        end
    end

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_en_i <= 1'b0;
    endtask

    // With w set, the write is followed at once by a read of the same place.
    task rd(input logic [3:0] a, input logic w, input logic [7:0] d, input logic [7:0] e, input string n);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= w;
        rd_en_i <= !w;
        if (w) begin
            @(posedge ref_clk_i);
            wr_en_i <= 1'b0;
            rd_en_i <= 1'b1;
        end
        @(posedge ref_clk_i);
        rd_en_i <= 1'b0;
        #1;
        `CHK(n, e, rd_data_o)
    endtask

    task lvl(input logic p2, input logic v, input int e, input string n);
        int k;
        k = 0;
        repeat (32) begin
            @(posedge ref_clk_i);
            #1;
            if ((p2 ? pwm_pin2_o : pwm_pin1_o) !== !v) k++;
        end
        `CHK(n, e, k)
    endtask

    task ev_gap(output int gap);
        int t;
        t = 0;
        gap = 0;
        while (tb_event_o !== 1'b1 && t < 2000) begin
            @(posedge ref_clk_i);
            #1;
            t++;
        end
        do begin
            @(posedge ref_clk_i);
            #1;
            gap++;
        end while (tb_event_o !== 1'b1 && gap < 2000);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i > 10 && i < 15) continue;
            rd(4'(i), 1'b0, 8'h00, (i == 1) ? 8'hFF : 8'h00, "reset value");
        end
        rd(cpw_pkg::OFS_TB_CTRL, 1'b1, 8'hFF, 8'h7F, "tb ctrl");
        rd(cpw_pkg::OFS_U2_MODE, 1'b1, 8'hFF, 8'h3F, "u2 mode");
        rd(cpw_pkg::OFS_PERIOD, 1'b1, 8'h03, 8'h03, "period");
        rd(cpw_pkg::OFS_U1_DUTY_WR, 1'b1, 8'h02, 8'h02, "u1 duty");
        wr(cpw_pkg::OFS_U2_DUTY_WR, 8'h01);
        for (int i = 2; i >= 0; i--) begin
            ps = 1 << (2 * i);
            wr(cpw_pkg::OFS_TB_CTRL, {1'b0, 4'h1, 1'b1, 2'(i)});
            wr(cpw_pkg::OFS_U1_MODE, 8'h2C);
            wr(cpw_pkg::OFS_U2_MODE, 8'h2C);
            repeat (48 * ps) @(posedge ref_clk_i);
            #1;
            `CHK("period 1", 16 * ps, per1)
            `CHK("period 2", 16 * ps, per2)
            `CHK("high 1", 10 * ps, hi1)
            `CHK("high 2", 6 * ps, hi2)
            ev_gap(g);
            `CHK("event gap", 32 * ps, g)
        end
        wr(cpw_pkg::OFS_U1_DUTY_ACT, 8'hAA);
        rd(cpw_pkg::OFS_U1_DUTY_ACT, 1'b0, 8'h00, 8'h02, "active ro");
        wr(cpw_pkg::OFS_U1_DUTY_WR, 8'h03);
        repeat (48) @(posedge ref_clk_i);
        rd(cpw_pkg::OFS_U1_DUTY_ACT, 1'b0, 8'h00, 8'h03, "active duty");
        `CHK("high 1 new", 14, hi1)
        wr(cpw_pkg::OFS_U1_DUTY_WR, 8'h20);
        repeat (48) @(posedge ref_clk_i);
        lvl(1'b0, 1'b0, 0, "pin 1 long duty");
        wr(cpw_pkg::OFS_U1_DUTY_WR, 8'h00);
        wr(cpw_pkg::OFS_U1_MODE, 8'h0C);
        repeat (48) @(posedge ref_clk_i);
        lvl(1'b0, 1'b1, 0, "pin 1 zero duty");
        wr(cpw_pkg::OFS_U1_DUTY_WR, 8'h02);
        wr(cpw_pkg::OFS_U1_MODE, 8'h2C);
        wr(cpw_pkg::OFS_SHUTDOWN, 8'h10);
        @(posedge ref_clk_i);
        shutdown_req_i <= 1'b1;
        @(posedge ref_clk_i);
        shutdown_req_i <= 1'b0;
        rd(cpw_pkg::OFS_SHUTDOWN, 1'b0, 8'h00, 8'h90, "shutdown");
        lvl(1'b0, 1'b1, 0, "pin 1 shut");
        lvl(1'b1, 1'b0, 20, "pin 2 no shutdown");
        wr(cpw_pkg::OFS_SHUTDOWN, 8'h00);
        repeat (48) @(posedge ref_clk_i);
        #1;
        `CHK("high 1 resumed", 10, hi1)
        wr(cpw_pkg::OFS_U2_MODE, 8'h00);
        repeat (48) @(posedge ref_clk_i);
        lvl(1'b1, 1'b1, 0, "pin 2 off");
        wr(cpw_pkg::OFS_TB_CTRL, 8'h00);
        wr(cpw_pkg::OFS_TB_COUNT, 8'h01);
        repeat (20) @(posedge ref_clk_i);
        rd(cpw_pkg::OFS_TB_COUNT, 1'b0, 8'h00, 8'h01, "count held");
        rd(cpw_pkg::OFS_U1_MODE, 1'b0, 8'h00, 8'h2C, "u1 mode");
        stop_test();
    end
endmodule // test_cpw_pwm_top
